/* design/robot_safety_interlock.sv */
`timescale 1ns/1ps
module robot_safety_interlock (
    input  wire logic i_core_clk,
    input  wire logic i_rstn,
    input  wire logic i_mode_a,
    input  wire logic i_mode_b,
    input  wire logic i_mode_c,
    input  wire logic i_estop_closed,
    input  wire logic i_door_closed,
    input  wire logic i_pendant_enable_switch,
    input  wire logic i_main_power_ready,
    output logic      o_contactor,
    output logic      o_estop_ready,
    output logic      o_auto_mode
);
    import interlock_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State: two-stage synchronisers per pin plus registered outputs
    typedef struct packed {
        logic [1:0] mode_a;
        logic [1:0] mode_b;
        logic [1:0] mode_c;
        logic [1:0] estop;
        logic [1:0] door;
        logic [1:0] enable;
        logic [1:0] mp_ready;
        logic       contactor;
        logic       ready;
        logic       auto_mode;
    } state_t;

    state_t cur;
    state_t next_cur;
    mode_t  mode;
    logic   auto_ok;
    logic   manual_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Selector decode, only the second sync stage is read
    always_comb begin
        if (cur.mode_a[1] && cur.mode_c[1] && !cur.mode_b[1]) begin
            mode = MODE_AUTO;
        end else if (!cur.mode_a[1] && !cur.mode_c[1] && cur.mode_b[1]) begin
            mode = MODE_MANUAL;
        end else begin
            mode = MODE_INVALID; // Broken or mid-travel selector fails safe
        end
    end

    // Mode permissives; enable switch is not a term of the automatic path
    assign auto_ok   = (mode == MODE_AUTO) && cur.estop[1] && cur.door[1];
    assign manual_ok = (mode == MODE_MANUAL) && cur.estop[1] && !cur.door[1]
                       && cur.enable[1];

    ////////////////////////////////////////////////////////////////////////////
    // Next state: shift synchronisers, recompute outputs every scan
    // Three scans from pin to output: two for metastability, one to decide;
    // that latency is the price of clean pin sampling at 4 ns per scan
    always_comb begin
        next_cur          = cur;
        next_cur.mode_a   = {cur.mode_a[0], i_mode_a};
        next_cur.mode_b   = {cur.mode_b[0], i_mode_b};
        next_cur.mode_c   = {cur.mode_c[0], i_mode_c};
        next_cur.estop    = {cur.estop[0], i_estop_closed};
        next_cur.door     = {cur.door[0], i_door_closed};
        next_cur.enable   = {cur.enable[0], i_pendant_enable_switch};
        next_cur.mp_ready = {cur.mp_ready[0], i_main_power_ready};
        next_cur.ready    = auto_ok || manual_ok;
        next_cur.contactor = (auto_ok || manual_ok) && cur.mp_ready[1];
        next_cur.auto_mode = (mode == MODE_AUTO);
        // Stop wins over contactor and ready, kept explicit for review
        if (cur.estop[1] == CONTACT_OPEN) begin
            next_cur.contactor = CONTACTOR_RST;
            next_cur.ready     = READY_RST;
        end
    end

    // Synchronous reset drops all outputs
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            cur.mode_a    <= SYNC_RST;
            cur.mode_b    <= SYNC_RST;
            cur.mode_c    <= SYNC_RST;
            cur.estop     <= SYNC_RST;
            cur.door      <= SYNC_RST;
            cur.enable    <= SYNC_RST;
            cur.mp_ready  <= SYNC_RST;
            cur.contactor <= CONTACTOR_RST;
            cur.ready     <= READY_RST;
            cur.auto_mode <= AUTO_MODE_RST;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from flops, so no decode glitch reaches a contactor
    assign o_contactor   = cur.contactor;
    assign o_estop_ready = cur.ready;
    assign o_auto_mode   = cur.auto_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on registered outputs against synchronised inputs and the stop pin
    // Antecedents on mode and contacts read the second sync stage, except the two pin-stop checks, so each check sees exactly
    // what the next-state logic saw one edge earlier
    property p_stop_drops;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !cur.estop[1] |=> !o_contactor && !o_estop_ready;
    endproperty
    a_stop_drops: assert property (p_stop_drops)
        else $error("contactor or ready on with stop open");

    property p_pin_stop_3;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !i_estop_closed [*3] |=> !o_contactor;
    endproperty
    a_pin_stop_3: assert property (p_pin_stop_3)
        else $error("contactor not dropped three scans after stop");

    property p_contactor_needs_ready;
        @(posedge i_core_clk) disable iff (!i_rstn)
        o_contactor |-> o_estop_ready;
    endproperty
    a_contactor_needs_ready: assert property (p_contactor_needs_ready)
        else $error("contactor on without ready");

    property p_auto_contactor;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (mode == MODE_AUTO) |=> (o_contactor == ($past(cur.estop[1]) && $past(cur.door[1])
                                 && $past(cur.mp_ready[1])));
    endproperty
    a_auto_contactor: assert property (p_auto_contactor)
        else $error("automatic contactor mismatch");

    property p_auto_ignores_enable;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (mode == MODE_AUTO) |=> (o_estop_ready == ($past(cur.estop[1]) && $past(cur.door[1])));
    endproperty
    a_auto_ignores_enable: assert property (p_auto_ignores_enable)
        else $error("automatic ready depends on more than stop and door");

    property p_manual_contactor;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (mode == MODE_MANUAL) |=> (o_contactor == ($past(cur.estop[1]) && !$past(cur.door[1])
                                   && $past(cur.enable[1]) && $past(cur.mp_ready[1])));
    endproperty
    a_manual_contactor: assert property (p_manual_contactor)
        else $error("manual contactor mismatch");

    property p_manual_door_closed;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (mode == MODE_MANUAL) && cur.door[1] |=> !o_contactor && !o_estop_ready;
    endproperty
    a_manual_door_closed: assert property (p_manual_door_closed)
        else $error("manual output on with door closed");

    property p_mode_decode;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (cur.mode_a[1] == cur.mode_b[1]) |=> !o_auto_mode && !o_estop_ready;
    endproperty
    a_mode_decode: assert property (p_mode_decode)
        else $error("illegal selector decoded as a mode");

    // Any selector set that is neither mode must leave the machine dead
    property p_invalid_off;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (mode == MODE_INVALID) |=> !o_contactor && !o_estop_ready && !o_auto_mode;
    endproperty
    a_invalid_off: assert property (p_invalid_off)
        else $error("invalid selector left an output on");

    // Indicator follows the decoded mode one scan later
    property p_auto_flag;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (mode != MODE_INVALID) |=> (o_auto_mode == ($past(mode) == MODE_AUTO));
    endproperty
    a_auto_flag: assert property (p_auto_flag)
        else $error("automatic indicator does not follow the selector");

    // Manual ready needs stop, open door and enable, never power ready
    property p_manual_ready;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (mode == MODE_MANUAL) |=> (o_estop_ready == ($past(cur.estop[1]) && !$past(cur.door[1])
                                   && $past(cur.enable[1])));
    endproperty
    a_manual_ready: assert property (p_manual_ready)
        else $error("manual ready mismatch");

    property p_contactor_needs_power;
        @(posedge i_core_clk) disable iff (!i_rstn)
        o_contactor |-> $past(cur.mp_ready[1]);
    endproperty
    a_contactor_needs_power: assert property (p_contactor_needs_power)
        else $error("contactor on without main power ready");

    property p_pin_stop_ready_3;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !i_estop_closed [*3] |=> !o_estop_ready;
    endproperty
    a_pin_stop_ready_3: assert property (p_pin_stop_ready_3)
        else $error("ready not dropped three scans after stop");

    // Main scenarios that the bench should reach

    c_auto_on: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_auto_mode && o_contactor);
    c_manual_on: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        !o_auto_mode && o_contactor);
    c_ready_no_power: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_estop_ready && !o_contactor);
    c_stop_drop: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_contactor ##1 !o_contactor);
    c_invalid_sel: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        (mode == MODE_INVALID) ##1 !o_auto_mode);
endmodule : robot_safety_interlock

/* design/interlock_pkg.sv */
package interlock_pkg;
    // Contact levels as seen after synchronisation: 1 means closed
    localparam logic CONTACT_CLOSED = 1'b1;
    localparam logic CONTACT_OPEN   = 1'b0;
    // Output reset values: everything de-energised
    localparam logic CONTACTOR_RST  = 1'b0;
    localparam logic READY_RST      = 1'b0;
    localparam logic AUTO_MODE_RST  = 1'b0;
    // Input synchroniser reset value
    localparam logic [1:0] SYNC_RST = 2'h0;

    // Decoded selector position
    typedef enum logic [1:0] {
        MODE_INVALID,
        MODE_AUTO,
        MODE_MANUAL
    } mode_t;
endpackage : interlock_pkg

/* dv/ctrl_partner.sv */
`timescale 1ns/1ps
module ctrl_partner (
    input  wire logic i_core_clk,
    input  wire logic i_power_ok,
    input  wire logic i_pendant_plugged,
    input  wire logic i_grip,
    output logic      o_main_power_ready,
    output logic      o_pendant_enable_switch,
    output logic      o_alarm
);
    ////////////////////////////////////////////////////////////////////////
    // Ready only when power may switch on and the pendant loop is closed;
    // an open pendant connector acts as an emergency stop in the controller
    always_ff @(posedge i_core_clk) begin
        o_main_power_ready <= i_power_ok & i_pendant_plugged;
    end
    // Status output for the host: open pendant connector is an alarm
    always_ff @(posedge i_core_clk) begin
        o_alarm <= ~i_pendant_plugged;
    end
    // Enable contact exists only while a pendant is attached
    assign o_pendant_enable_switch = i_grip & i_pendant_plugged;
endmodule : ctrl_partner

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import interlock_pkg::*;
    logic       clk, rstn, stop, door, grip, pwr, plug, mp, en, cont, rdy, auto, alarm;
    logic [2:0] sel;
    int         n_mismatch, total_checks;

    ctrl_partner u_ctrl (.i_core_clk(clk), .i_power_ok(pwr), .i_pendant_plugged(plug),
        .i_grip(grip), .o_main_power_ready(mp), .o_pendant_enable_switch(en),
        .o_alarm(alarm));
    robot_safety_interlock u_dut (.i_core_clk(clk), .i_rstn(rstn), .i_mode_a(sel[2]),
        .i_mode_b(sel[1]), .i_mode_c(sel[0]), .i_estop_closed(stop), .i_door_closed(door),
        .i_pendant_enable_switch(en), .i_main_power_ready(mp), .o_contactor(cont),
        .o_estop_ready(rdy), .o_auto_mode(auto));

    ////////////////////////////////////////////////////////////////////////
    task chk(input string name, input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", name, exp, seen);
        end
    endtask : chk
    task outs(input logic c, input logic r, input logic a);
        chk("contactor", cont, c);
        chk("estop_ready", rdy, r);
        chk("auto_mode", auto, a);
    endtask : outs
    // Sync plus partner register gives four edges; five leaves margin
    task drive(input logic [2:0] s, input logic st, d, g, p, pl);
        @(posedge clk);
        #1;
        sel = s;
        stop = st;
        door = d;
        grip = g;
        pwr = p;
        plug = pl;
        repeat (5) @(posedge clk);
        #1;
    endtask : drive
    task summarize();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////
    task t_auto();
        drive(3'h5, 1, 1, 0, 1, 1);
        outs(1, 1, 1);
        drive(3'h5, 1, 1, 1, 1, 1);
        outs(1, 1, 1);
        drive(3'h5, 1, 1, 1, 0, 1);
        outs(0, 1, 1);
        drive(3'h5, 1, 0, 1, 1, 1);
        outs(0, 0, 1);
    endtask : t_auto
    task t_estop();
        drive(3'h5, 0, 1, 0, 1, 1);
        outs(0, 0, 1);
        drive(3'h2, 0, 0, 1, 1, 1);
        outs(0, 0, 0);
    endtask : t_estop
    task t_manual();
        drive(3'h2, 1, 0, 1, 1, 1);
        outs(1, 1, 0);
        chk("alarm", alarm, 0);
        drive(3'h2, 1, 0, 0, 1, 1);
        outs(0, 0, 0);
        drive(3'h2, 1, 0, 1, 0, 1);
        outs(0, 1, 0);
        drive(3'h2, 1, 1, 1, 1, 1);
        outs(0, 0, 0);
        drive(3'h2, 1, 0, 1, 1, 0);
        outs(0, 0, 0);
        chk("alarm", alarm, 1);
    endtask : t_manual
    // Stop pressed with all else good: the drop lands on the third edge
    task t_latency();
        drive(3'h5, 1, 1, 0, 1, 1);
        outs(1, 1, 1);
        stop = 0;
        repeat (2) @(posedge clk);
        #1;
        chk("contactor_early", cont, 1);
        @(posedge clk);
        #1;
        outs(0, 0, 1);
    endtask : t_latency
    // Reset in mid-run drops outputs; they return once synchronisers refill
    task t_reset();
        drive(3'h5, 1, 1, 0, 1, 1);
        outs(1, 1, 1);
        rstn = 0;
        @(posedge clk);
        #1;
        outs(0, 0, 0);
        rstn = 1;
        @(posedge clk);
        #1;
        outs(0, 0, 0);
        repeat (2) @(posedge clk);
        #1;
        outs(1, 1, 1);
    endtask : t_reset
    // Contact sets that are neither mode must leave everything off
    task t_invalid();
        logic [2:0] bad [4];
        bad = '{3'h6, 3'h4, 3'h7, 3'h0};
        foreach (bad[i]) begin
            drive(bad[i], 1, 1, 1, 1, 1);
            outs(0, 0, 0);
        end
    endtask : t_invalid

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    initial begin
        n_mismatch = 0;
        total_checks = 0;
        rstn = 0;
        sel = 3'h5;
        stop = 1;
        door = 1;
        grip = 0;
        pwr = 1;
        plug = 1;
        repeat (8) @(posedge clk);
        #1;
        outs(0, 0, 0);
        rstn = 1;
        t_auto();
        t_estop();
        t_manual();
        t_latency();
        t_reset();
        t_invalid();
        summarize();
    end
    // Whole sequence needs about 120 cycles; cut a hang well beyond that
    initial begin
        #20000;
        n_mismatch++;
        summarize();
    end
endmodule : testbench
